// ---- tpc_pkg.sv ----
package tpc_pkg;
	// Bus geometry: word index is the byte address divided by four
	localparam int ADDR_W = 18;
	localparam logic [11:0] IDX_CH4_PAGE = 12'hFE9;
	localparam logic [11:0] IDX_CH5_PAGE = 12'hFEA;
	localparam logic [15:0] IDX_CH4_GEN_A = 16'hFE98;
	localparam logic [15:0] IDX_CH4_GEN_B = 16'hFE9A;

	// Register slots inside a channel page
	localparam logic [3:0] SUB_CTRL = 4'h0;
	localparam logic [3:0] SUB_MODE = 4'h1;
	localparam logic [3:0] SUB_IO = 4'h2;
	localparam logic [3:0] SUB_IER = 4'h4;
	localparam logic [3:0] SUB_SR = 4'h5;
	localparam logic [3:0] SUB_CNT = 4'h6;
	localparam logic [3:0] SUB_GEN_A = IDX_CH4_GEN_A[3:0];
	localparam logic [3:0] SUB_GEN_B = IDX_CH4_GEN_B[3:0];

	// Reset values and bits that always read as one
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_MODE = 8'hC0;
	localparam logic [7:0] RST_IO = 8'h00;
	localparam logic [7:0] RST_IER = 8'h40;
	localparam logic [7:0] RST_SR = 8'hC0;
	localparam logic [7:0] RD1_MODE = 8'hC0;
	localparam logic [7:0] RD1_IER = 8'h40;
	localparam logic [7:0] RD1_SR = 8'h40;

	// Field positions
	localparam int IER_CONV = 7;
	localparam int IER_UNF = 5;
	localparam int IER_OVF = 4;
	localparam int IER_B = 1;
	localparam int IER_A = 0;
	localparam int SR_DIR = 7;
	localparam int SR_UNF = 5;
	localparam int SR_OVF = 4;
	localparam int SR_B = 1;
	localparam int SR_A = 0;
	localparam int MD_PHASE_BIT = 2;

	// Count source codes
	localparam logic [2:0] TPSC_DIV1 = 3'h0;
	localparam logic [2:0] TPSC_DIV4 = 3'h1;
	localparam logic [2:0] TPSC_DIV16 = 3'h2;
	localparam logic [2:0] TPSC_DIV64 = 3'h3;
	localparam logic [2:0] TPSC_EXT_A = 3'h4;
	localparam logic [2:0] TPSC_EXT_C = 3'h5;
	localparam logic [2:0] TPSC_SIX = 3'h6;

	// Counter clear codes
	localparam logic [1:0] CCLR_A = 2'h1;
	localparam logic [1:0] CCLR_B = 2'h2;
	localparam logic [1:0] CCLR_SYNC = 2'h3;

	// Compare output actions
	localparam logic [1:0] OUT_ZERO = 2'h1;
	localparam logic [1:0] OUT_ONE = 2'h2;
	localparam logic [1:0] OUT_TOGGLE = 2'h3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [1:0] cclr;
		logic [1:0] ckeg;
		logic [2:0] tpsc;
		logic [3:0] md;
		logic [3:0] io_a;
		logic [3:0] io_b;
		logic conv_en, ien_u, ien_v, ien_b, ien_a;
		logic f_dir, f_u, f_v, f_b, f_a;
		logic [3:0] arm;
		logic [15:0] cnt;
		logic [15:0] gra;
		logic [15:0] grb;
		logic pin_a, pin_b;
	} tpc_chan_t;

	typedef struct packed {
		logic aw_got, w_got;
		logic [15:0] awidx;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} tpc_axi_t;

	typedef struct packed {
		tpc_chan_t [1:0] ch;
		tpc_axi_t axi;
		logic [9:0] div;
		logic [7:0] s1, s2, s3, lv, lvp;
		logic [1:0] ovf_p, unf_p, adc;
	} tpc_state_t;
endpackage : tpc_pkg

// ---- tpc_top.sv ----
`timescale 1ns/1ns
// Function
// - Mode field bit 2 picks phase counting; all other mode codes count as normal mode.
// - Compare registers drive disabled, initial 0 or 1, then 0, 1 or toggle.
// - Capture registers latch counter on rising, falling or both pin edges.
// - Channel 4 register A captures on channel 3 register A events.
// - Channel 4 register B captures on channel 3 register C events.
// - Register A and B requests only while their enable bits are one.
// - Overflow and underflow requests only while their enable bits are one.
// - Conversion start requests only while the trigger enable bit is one.
// - Match flag sets on compare equality or on capture transfer.
// - DMA acknowledge clears the A flag when its select bit is one.
// - Transfer controller acknowledge clears a flag when its select bit is zero.
// - Overflow flag sets when the counter wraps upward to zero.
// - Underflow flag sets when the counter wraps downward to all ones.
// - Flags clear by writing zero after reading one; A and B flags also clear on acknowledges.
// - Counting down only in phase mode or cascaded overflow/underflow counting.
// - Channel 5 source: clock by 1, 4, 16, 64, 256, or pins A, C, D.
// - Phase counting mode ignores prescaler and clock edge settings.
// - Counter clear: none, on A event, on B event, or synchronous clear.
module tpc_top (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic [tpc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [tpc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [3:0] CLK_PIN,
	input wire logic [3:0] TIO_IN,
	output logic [3:0] TIO_OUT,
	output logic [3:0] TIO_OE,
	input wire logic CH3_A_EVENT,
	input wire logic CH3_C_EVENT,
	input wire logic [1:0] SYNC_CLR_IN,
	input wire logic [3:0] XFER_CTRL_ACK,
	input wire logic XFER_IRQ_SEL,
	input wire logic [1:0] DMA_ACK,
	input wire logic DMA_ACK_SEL,
	output logic [1:0] REG_A_IRQ,
	output logic [1:0] REG_B_IRQ,
	output logic [1:0] OVERFLOW_IRQ,
	output logic [1:0] UNDERFLOW_IRQ,
	output logic [1:0] ADC_START
);
	tpc_pkg::tpc_state_t st_q;
	tpc_pkg::tpc_state_t st_d;

	// Edge picker shared by count sources and capture pins
	function automatic logic edge_hit(input logic prev, input logic cur, input logic [1:0] sel);
		if (sel[1]) begin
			return prev != cur;
		end else if (sel[0]) begin
			return prev & ~cur;
		end
		return ~prev & cur;
	endfunction : edge_hit

	// Word index to {hit, channel, slot}
	function automatic logic [5:0] reg_decode(input logic [15:0] idx);
		logic hit;
		logic ch;
		hit = 1'b0;
		ch = 1'b0;
		if (idx[15:4] == tpc_pkg::IDX_CH4_PAGE) begin
			hit = 1'b1;
		end else if (idx[15:4] == tpc_pkg::IDX_CH5_PAGE) begin
			hit = 1'b1;
			ch = 1'b1;
		end
		case (idx[3:0])
			tpc_pkg::SUB_CTRL, tpc_pkg::SUB_MODE, tpc_pkg::SUB_IO, tpc_pkg::SUB_IER,
			tpc_pkg::SUB_SR, tpc_pkg::SUB_CNT, tpc_pkg::SUB_GEN_A, tpc_pkg::SUB_GEN_B: begin
				return {hit, ch, idx[3:0]};
			end
			default: begin
				return {1'b0, ch, idx[3:0]};
			end
		endcase
	endfunction : reg_decode

	// Byte-lane merge for the sixteen-bit registers
	function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] wd,
			input logic [3:0] strb);
		logic [15:0] v;
		v = old;
		if (strb[0]) begin
			v[7:0] = wd[7:0];
		end
		if (strb[1]) begin
			v[15:8] = wd[15:8];
		end
		return v;
	endfunction : lane16

	// Match or capture event of one general register
	function automatic logic chan_event(input logic [3:0] io, input logic step,
			input logic [15:0] cnt_n, input logic [15:0] gr, input logic pinp,
			input logic pin, input logic casc, input logic casc_ok);
		if (!io[3]) begin
			return step && (cnt_n == gr);
		end else if (io[2] && casc_ok) begin
			return casc;
		end
		return edge_hit(pinp, pin, io[1:0]);
	endfunction : chan_event

	// Compare pin action at a match
	function automatic logic pin_act(input logic [3:0] io, input logic ev, input logic cur);
		if (io[3] || !ev) begin
			return cur;
		end
		case (io[1:0])
			tpc_pkg::OUT_ZERO: return 1'b0;
			tpc_pkg::OUT_ONE: return 1'b1;
			tpc_pkg::OUT_TOGGLE: return ~cur;
			default: return cur;
		endcase
	endfunction : pin_act

	// All next-state logic
	always_comb begin
		tpc_pkg::tpc_chan_t ch;
		tpc_pkg::tpc_chan_t nch;
		logic up, dn, ev_a, ev_b, clr, pa, pb, pap, pbp, xa, xb, do_wr;
		logic [15:0] cnt_n;
		logic [5:0] wdec, rdec;
		logic [31:0] wd, rd;
		logic [3:0] swc;
		logic [7:0] b8;
		ch = '0;
		nch = '0;
		up = 1'b0;
		dn = 1'b0;
		ev_a = 1'b0;
		ev_b = 1'b0;
		clr = 1'b0;
		pa = 1'b0;
		pb = 1'b0;
		pap = 1'b0;
		pbp = 1'b0;
		xa = 1'b0;
		xb = 1'b0;
		cnt_n = 16'h0000;
		swc = 4'h0;
		b8 = 8'h00;
		rd = 32'h0000_0000;
		st_d = st_q;
		wd = st_q.axi.wdata;
		wdec = reg_decode(st_q.axi.awidx);
		do_wr = st_q.axi.aw_got & st_q.axi.w_got & ~st_q.axi.bvalid;

		// Three-stage pin filter: a level counts once stages two and three agree
		st_d.s1 = {TIO_IN, CLK_PIN};
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		for (int p = 0; p < 8; p++) begin
			if (st_q.s2[p] == st_q.s3[p]) begin
				st_d.lv[p] = st_q.s3[p];
			end
		end
		st_d.lvp = st_q.lv;
		st_d.div = st_q.div + 10'h001;
		st_d.adc = 2'b00;
		st_d.ovf_p = 2'b00;
		st_d.unf_p = 2'b00;

		// Channel 5 first; channel 4 takes its wrap pulses from st_q, so one cycle late
		for (int c = 1; c >= 0; c--) begin
			ch = st_q.ch[c];
			nch = ch;
			up = 1'b0;
			dn = 1'b0;
			pa = st_q.lv[2*c];
			pb = st_q.lv[2*c+1];
			pap = st_q.lvp[2*c];
			pbp = st_q.lvp[2*c+1];
			if (ch.md[tpc_pkg::MD_PHASE_BIT]) begin
				// Quadrature decode; prescaler and edge fields play no part
				if (pa != pap && pb == pbp) begin
					up = pa ^ pb;
					dn = ~(pa ^ pb);
				end else if (pb != pbp && pa == pap) begin
					up = ~(pa ^ pb);
					dn = pa ^ pb;
				end
			end else begin
				case (ch.tpsc)
					tpc_pkg::TPSC_DIV1: up = 1'b1;
					tpc_pkg::TPSC_DIV4: up = edge_hit(st_q.div[1], st_d.div[1], ch.ckeg);
					tpc_pkg::TPSC_DIV16: up = edge_hit(st_q.div[3], st_d.div[3], ch.ckeg);
					tpc_pkg::TPSC_DIV64: up = edge_hit(st_q.div[5], st_d.div[5], ch.ckeg);
					tpc_pkg::TPSC_EXT_A: up = edge_hit(st_q.lvp[0], st_q.lv[0], ch.ckeg);
					tpc_pkg::TPSC_EXT_C: up = edge_hit(st_q.lvp[2], st_q.lv[2], ch.ckeg);
					tpc_pkg::TPSC_SIX: begin
						if (c == 1) begin
							up = edge_hit(st_q.div[7], st_d.div[7], ch.ckeg);
						end else begin
							up = edge_hit(st_q.div[9], st_d.div[9], ch.ckeg);
						end
					end
					default: begin
						if (c == 1) begin
							up = edge_hit(st_q.lvp[3], st_q.lv[3], ch.ckeg);
						end else begin
							up = st_q.ovf_p[1];
							dn = st_q.unf_p[1];
						end
					end
				endcase
			end
			if (up) begin
				cnt_n = ch.cnt + 16'h0001;
			end else if (dn) begin
				cnt_n = ch.cnt - 16'h0001;
			end else begin
				cnt_n = ch.cnt;
			end
			ev_a = chan_event(ch.io_a, up | dn, cnt_n, ch.gra, st_q.lvp[4+2*c],
				st_q.lv[4+2*c], CH3_A_EVENT, c == 0);
			ev_b = chan_event(ch.io_b, up | dn, cnt_n, ch.grb, st_q.lvp[5+2*c],
				st_q.lv[5+2*c], CH3_C_EVENT, c == 0);
			clr = (ch.cclr == tpc_pkg::CCLR_A && ev_a)
				|| (ch.cclr == tpc_pkg::CCLR_B && ev_b)
				|| (ch.cclr == tpc_pkg::CCLR_SYNC && SYNC_CLR_IN[c]);
			nch.cnt = clr ? 16'h0000 : cnt_n;
			if (up) begin
				nch.f_dir = 1'b1;
			end else if (dn) begin
				nch.f_dir = 1'b0;
			end

			// Software writes land after counting, so a counter write wins
			swc = 4'h0;
			if (do_wr && wdec[5] && int'(wdec[4]) == c && st_q.axi.wstrb[0]) begin
				case (wdec[3:0])
					tpc_pkg::SUB_CTRL: {nch.cclr, nch.ckeg, nch.tpsc} = wd[6:0];
					tpc_pkg::SUB_MODE: nch.md = wd[3:0];
					tpc_pkg::SUB_IO: begin
						nch.io_a = wd[3:0];
						nch.io_b = wd[7:4];
						nch.pin_a = wd[2];
						nch.pin_b = wd[6];
					end
					tpc_pkg::SUB_IER: begin
						nch.conv_en = wd[tpc_pkg::IER_CONV];
						nch.ien_u = wd[tpc_pkg::IER_UNF];
						nch.ien_v = wd[tpc_pkg::IER_OVF];
						nch.ien_b = wd[tpc_pkg::IER_B];
						nch.ien_a = wd[tpc_pkg::IER_A];
					end
					tpc_pkg::SUB_SR: begin
						// Zero clears only a flag seen as one; ones do nothing
						swc = ch.arm & ~{wd[tpc_pkg::SR_UNF], wd[tpc_pkg::SR_OVF],
							wd[tpc_pkg::SR_B], wd[tpc_pkg::SR_A]};
						nch.arm = 4'h0;
					end
					default: begin
					end
				endcase
			end
			if (do_wr && wdec[5] && int'(wdec[4]) == c) begin
				case (wdec[3:0])
					tpc_pkg::SUB_CNT: nch.cnt = lane16(nch.cnt, wd, st_q.axi.wstrb);
					tpc_pkg::SUB_GEN_A: nch.gra = lane16(ch.gra, wd, st_q.axi.wstrb);
					tpc_pkg::SUB_GEN_B: nch.grb = lane16(ch.grb, wd, st_q.axi.wstrb);
					default: begin
					end
				endcase
			end

			// Capture beats a same-cycle software write to the register
			if (ch.io_a[3] && ev_a) begin
				nch.gra = ch.cnt;
			end
			if (ch.io_b[3] && ev_b) begin
				nch.grb = ch.cnt;
			end
			nch.pin_a = pin_act(ch.io_a, ev_a, nch.pin_a);
			nch.pin_b = pin_act(ch.io_b, ev_b, nch.pin_b);

			// Flags: a set in the clearing cycle wins
			xa = (XFER_CTRL_ACK[2*c] & ~XFER_IRQ_SEL) | (DMA_ACK[c] & DMA_ACK_SEL);
			xb = XFER_CTRL_ACK[2*c+1] & ~XFER_IRQ_SEL;
			nch.f_a = ev_a | (ch.f_a & ~(xa | swc[0]));
			nch.f_b = ev_b | (ch.f_b & ~(xb | swc[1]));
			st_d.ovf_p[c] = up && ch.cnt == 16'hFFFF;
			st_d.unf_p[c] = dn && ch.cnt == 16'h0000;
			nch.f_v = st_d.ovf_p[c] | (ch.f_v & ~swc[2]);
			nch.f_u = st_d.unf_p[c] | (ch.f_u & ~swc[3]);
			st_d.adc[c] = ch.conv_en & ev_a;
			st_d.ch[c] = nch;
		end

		// Write channels: address and data held in either order
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			st_d.axi.aw_got = 1'b1;
			st_d.axi.awidx = S_AXI_AWADDR[tpc_pkg::ADDR_W-1:2];
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			st_d.axi.w_got = 1'b1;
			st_d.axi.wdata = S_AXI_WDATA;
			st_d.axi.wstrb = S_AXI_WSTRB;
		end
		if (do_wr) begin
			st_d.axi.aw_got = 1'b0;
			st_d.axi.w_got = 1'b0;
			st_d.axi.bvalid = 1'b1;
			st_d.axi.bresp = wdec[5] ? tpc_pkg::RESP_OKAY : tpc_pkg::RESP_SLVERR;
		end else if (st_q.axi.bvalid && S_AXI_BREADY) begin
			st_d.axi.bvalid = 1'b0;
		end

		// Read channel: reading status arms the flags it shows
		rdec = reg_decode(S_AXI_ARADDR[tpc_pkg::ADDR_W-1:2]);
		ch = st_q.ch[rdec[4]];
		case (rdec[3:0])
			tpc_pkg::SUB_CTRL: rd = {25'h0, ch.cclr, ch.ckeg, ch.tpsc};
			tpc_pkg::SUB_MODE: rd = {24'h0, tpc_pkg::RD1_MODE | {4'h0, ch.md}};
			tpc_pkg::SUB_IO: rd = {24'h0, ch.io_b, ch.io_a};
			tpc_pkg::SUB_IER: begin
				b8 = tpc_pkg::RD1_IER;
				b8[tpc_pkg::IER_CONV] = ch.conv_en;
				b8[tpc_pkg::IER_UNF] = ch.ien_u;
				b8[tpc_pkg::IER_OVF] = ch.ien_v;
				b8[tpc_pkg::IER_B] = ch.ien_b;
				b8[tpc_pkg::IER_A] = ch.ien_a;
				rd = {24'h0, b8};
			end
			tpc_pkg::SUB_SR: begin
				b8 = tpc_pkg::RD1_SR;
				b8[tpc_pkg::SR_DIR] = ch.f_dir;
				b8[tpc_pkg::SR_UNF] = ch.f_u;
				b8[tpc_pkg::SR_OVF] = ch.f_v;
				b8[tpc_pkg::SR_B] = ch.f_b;
				b8[tpc_pkg::SR_A] = ch.f_a;
				rd = {24'h0, b8};
			end
			tpc_pkg::SUB_CNT: rd = {16'h0, ch.cnt};
			tpc_pkg::SUB_GEN_A: rd = {16'h0, ch.gra};
			tpc_pkg::SUB_GEN_B: rd = {16'h0, ch.grb};
			default: rd = 32'h0000_0000;
		endcase
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			st_d.axi.rvalid = 1'b1;
			st_d.axi.rdata = rdec[5] ? rd : 32'h0000_0000;
			st_d.axi.rresp = rdec[5] ? tpc_pkg::RESP_OKAY : tpc_pkg::RESP_SLVERR;
			if (rdec[5] && rdec[3:0] == tpc_pkg::SUB_SR) begin
				st_d.ch[rdec[4]].arm = st_d.ch[rdec[4]].arm
					| {ch.f_u, ch.f_v, ch.f_b, ch.f_a};
			end
		end else if (st_q.axi.rvalid && S_AXI_RREADY) begin
			st_d.axi.rvalid = 1'b0;
		end
	end

	// State register
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_q <= '0;
			for (int c = 0; c < 2; c++) begin
				st_q.ch[c].f_dir <= tpc_pkg::RST_SR[tpc_pkg::SR_DIR];
			end
		end else begin
			st_q <= st_d;
		end
	end

	// Bus handshakes; a pending answer blocks new requests
	assign S_AXI_AWREADY = ~st_q.axi.aw_got & ~st_q.axi.bvalid;
	assign S_AXI_WREADY = ~st_q.axi.w_got & ~st_q.axi.bvalid;
	assign S_AXI_BVALID = st_q.axi.bvalid;
	assign S_AXI_BRESP = st_q.axi.bresp;
	assign S_AXI_ARREADY = ~st_q.axi.rvalid;
	assign S_AXI_RVALID = st_q.axi.rvalid;
	assign S_AXI_RDATA = st_q.axi.rdata;
	assign S_AXI_RRESP = st_q.axi.rresp;

	// Pins: driven only in compare mode with an action selected
	assign TIO_OUT = {st_q.ch[1].pin_b, st_q.ch[1].pin_a, st_q.ch[0].pin_b, st_q.ch[0].pin_a};
	assign TIO_OE = {~st_q.ch[1].io_b[3] & (|st_q.ch[1].io_b[1:0]),
		~st_q.ch[1].io_a[3] & (|st_q.ch[1].io_a[1:0]),
		~st_q.ch[0].io_b[3] & (|st_q.ch[0].io_b[1:0]),
		~st_q.ch[0].io_a[3] & (|st_q.ch[0].io_a[1:0])};

	// Requests gated by their enables
	assign REG_A_IRQ = {st_q.ch[1].f_a & st_q.ch[1].ien_a,
		st_q.ch[0].f_a & st_q.ch[0].ien_a};
	assign REG_B_IRQ = {st_q.ch[1].f_b & st_q.ch[1].ien_b,
		st_q.ch[0].f_b & st_q.ch[0].ien_b};
	assign OVERFLOW_IRQ = {st_q.ch[1].f_v & st_q.ch[1].ien_v,
		st_q.ch[0].f_v & st_q.ch[0].ien_v};
	assign UNDERFLOW_IRQ = {st_q.ch[1].f_u & st_q.ch[1].ien_u,
		st_q.ch[0].f_u & st_q.ch[0].ien_u};
	assign ADC_START = st_q.adc;
endmodule : tpc_top

// ---- tpc_properties.sv ----
`timescale 1ns/1ns
// Bus and pin relations of the timer pair, seen from its top ports only
module tpc_chk (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [3:0] TIO_OE,
	input wire logic [1:0] REG_A_IRQ,
	input wire logic [1:0] ADC_START
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	// Write steps: both halves taken, then the answer handed over
	sequence s_wr_taken;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	sequence s_b_done;
		S_AXI_BVALID && S_AXI_BREADY;
	endsequence
	a_write_answer:
	assert property (s_wr_taken |-> ##2 S_AXI_BVALID) else $error("write answer late");
	a_bresp_hold:
	assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write answer dropped");
	a_b_release:
	assert property (s_b_done |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY)
		else $error("write side not freed");
	a_b_blocks:
	assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write taken while answer pending");
	a_read_answer:
	assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
		else $error("read answer late");
	a_rdata_hold:
	assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data moved");
	a_rdata_width:
	assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000)
		else $error("read data wider than register");
	a_slverr_zero:
	assert property (S_AXI_RVALID && S_AXI_RRESP == tpc_pkg::RESP_SLVERR |-> S_AXI_RDATA == 32'h0)
		else $error("unmapped read returned data");
	a_reset_quiet:
	assert property ($rose(RST_N) |-> TIO_OE == 4'h0 && REG_A_IRQ == 2'h0 && ADC_START == 2'h0)
		else $error("outputs active after reset");
endmodule : tpc_chk

bind tpc_top tpc_chk chk_u (.REF_CLK(REF_CLK), .RST_N(RST_N), .S_AXI_AWVALID(S_AXI_AWVALID),
	.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
	.S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
	.TIO_OE(TIO_OE), .REG_A_IRQ(REG_A_IRQ), .ADC_START(ADC_START));

// ---- tpc_far.sv ----
`timescale 1ns/1ns
// Pins and neighbouring channel logic around the timer pair
module tpc_far (
	input wire logic clk,
	output logic [3:0] clk_pin,
	output logic [3:0] tio_in,
	output logic ch3_a,
	output logic ch3_c,
	output logic [3:0] xfer_ack,
	output logic xfer_sel,
	output logic [1:0] dma_ack,
	output logic dma_sel
);
	// Quiet pins and idle event lines from time zero
	initial begin
		clk_pin = 4'h0;
		tio_in = 4'h0;
		ch3_a = 1'b0;
		ch3_c = 1'b0;
		xfer_ack = 4'h0;
		xfer_sel = 1'b0;
		dma_ack = 2'h0;
		dma_sel = 1'b0;
	end
	// One-cycle event pulse, same clock as the timer
	task automatic pulse(input int which);
		@(posedge clk);
		case (which)
			0: ch3_a <= 1'b1;
			1: ch3_c <= 1'b1;
			2: dma_ack[0] <= 1'b1;
			default: xfer_ack[1] <= 1'b1;
		endcase
		@(posedge clk);
		ch3_a <= 1'b0;
		ch3_c <= 1'b0;
		dma_ack <= 2'h0;
		xfer_ack <= 4'h0;
	endtask : pulse
	// Phase D leads phase C; slow steps so the pin filters see each one
	task automatic quad_down(input int steps);
		logic [1:0] ph;
		int i;
		ph = clk_pin[3:2];
		for (i = 0; i < steps; i++) begin
			repeat (8) @(posedge clk);
			ph = {~ph[0], ph[1]};
			clk_pin[3:2] <= ph;
		end
	endtask : quad_down
endmodule : tpc_far

// ---- tpc_top_test.sv ----
`timescale 1ns/1ns
module tpc_top_test;
	logic REF_CLK = 1'b0;
	logic RST_N = 1'b0;
	logic [17:0] awaddr = 18'h0, araddr = 18'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, rd_q;
	logic awready, wready, bvalid, arready, rvalid, ch3_a, ch3_c, xsel, dsel;
	logic [1:0] bresp, rresp, b_seen, rr_q, irq_a, irq_b, irq_v, irq_u, adc, dack;
	logic [1:0] sync = 2'h0;
	logic [3:0] strb = 4'hF;
	logic [3:0] cpin, tin, tio_out, tio_oe, xack, code;
	logic [3:0] codes [6] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7};
	logic exp;
	int errors = 0, compares = 0, adc_n = 0, c, n;
	// Free-running 50 MHz clock
	always #10 REF_CLK = ~REF_CLK;
	// Channel 5 conversion start pulses counted as they pass
	always @(posedge REF_CLK) begin
		if (adc[1] === 1'b1) adc_n++;
	end
	tpc_top dut_u (.REF_CLK(REF_CLK), .RST_N(RST_N), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(strb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.CLK_PIN(cpin), .TIO_IN(tin), .TIO_OUT(tio_out), .TIO_OE(tio_oe), .CH3_A_EVENT(ch3_a),
		.CH3_C_EVENT(ch3_c), .SYNC_CLR_IN(sync), .XFER_CTRL_ACK(xack), .XFER_IRQ_SEL(xsel),
		.DMA_ACK(dack), .DMA_ACK_SEL(dsel), .REG_A_IRQ(irq_a), .REG_B_IRQ(irq_b),
		.OVERFLOW_IRQ(irq_v), .UNDERFLOW_IRQ(irq_u), .ADC_START(adc));
	tpc_far far_u (.clk(REF_CLK), .clk_pin(cpin), .tio_in(tin), .ch3_a(ch3_a), .ch3_c(ch3_c),
		.xfer_ack(xack), .xfer_sel(xsel), .dma_ack(dack), .dma_sel(dsel));
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
		compares++;
		if (seen !== want) begin
			errors++;
			$display("BAD %s exp %h seen %h", nm, want, seen);
		end
	endtask : check
	task automatic final_report;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report
	// Byte address of a register slot in a channel page
	function automatic logic [17:0] adr(input logic ch, input logic [3:0] slot);
		return {(ch ? tpc_pkg::IDX_CH5_PAGE : tpc_pkg::IDX_CH4_PAGE), slot, 2'b00};
	endfunction : adr
	// Readiness sampled at the falling edge, so it is the value the next rise sees
	task automatic wr(input logic ch, input logic [3:0] slot, input logic [15:0] d);
		logic a_hit, w_hit, b_hit;
		@(posedge REF_CLK);
		awaddr <= adr(ch, slot);
		awvalid <= 1'b1;
		wdata <= {16'h0000, d};
		wvalid <= 1'b1;
		bready <= 1'b1;
		b_hit = 1'b0;
		for (int k = 0; k < 40 && !b_hit; k++) begin
			@(negedge REF_CLK);
			a_hit = awvalid && awready;
			w_hit = wvalid && wready;
			b_hit = bvalid;
			b_seen = bresp;
			@(posedge REF_CLK);
			if (a_hit) awvalid <= 1'b0;
			if (w_hit) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		if (!b_hit) check("write wait", 32'h0, 32'h1);
		if (!b_hit) final_report();
	endtask : wr
	task automatic rd(input logic ch, input logic [3:0] slot);
		logic a_hit, r_hit;
		@(posedge REF_CLK);
		araddr <= adr(ch, slot);
		arvalid <= 1'b1;
		rready <= 1'b1;
		r_hit = 1'b0;
		for (int k = 0; k < 40 && !r_hit; k++) begin
			@(negedge REF_CLK);
			a_hit = arvalid && arready;
			r_hit = rvalid;
			rd_q = rdata;
			rr_q = rresp;
			@(posedge REF_CLK);
			if (a_hit) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		if (!r_hit) check("read wait", 32'h0, 32'h1);
		if (!r_hit) final_report();
	endtask : rd
	task automatic rc(input string nm, input logic ch, input logic [3:0] s, input logic [31:0] m,
		input logic [31:0] want);
		rd(ch, s);
		check(nm, rd_q & m, want);
	endtask : rc
	// Waits on channel 5 request 0 reg A, 1 overflow, 2 underflow
	task automatic wait_for(input int which);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < 600 && hit !== 1'b1; k++) begin
			@(negedge REF_CLK);
			hit = (which == 0) ? irq_a[1] : (which == 1) ? irq_v[1] : irq_u[1];
		end
		if (hit !== 1'b1) check("irq wait", 32'h0, 32'h1);
		if (hit !== 1'b1) final_report();
	endtask : wait_for
	initial begin
		repeat (3) @(posedge REF_CLK);
		RST_N <= 1'b1;
		// Reset values, then a hole in the map
		for (c = 0; c < 2; c++) begin
			rc("ctrl", c[0], tpc_pkg::SUB_CTRL, 32'hFFFFFFFF, 32'h00);
			rc("mode", c[0], tpc_pkg::SUB_MODE, 32'hFFFFFFFF, 32'hC0);
			rc("io", c[0], tpc_pkg::SUB_IO, 32'hFFFFFFFF, 32'h00);
			rc("ier", c[0], tpc_pkg::SUB_IER, 32'hFFFFFFFF, 32'h40);
			rc("sr", c[0], tpc_pkg::SUB_SR, 32'hFFFFFFFF, 32'hC0);
		end
		rc("hole", 1'b0, 4'h3, 32'hFFFFFFFF, 32'h0);
		check("hole rresp", rr_q, tpc_pkg::RESP_SLVERR);
		wr(1'b0, 4'h3, 16'hFFFF);
		check("hole bresp", b_seen, tpc_pkg::RESP_SLVERR);
		// Channel 4 held still on an idle pin, captures from channel 3 events
		wr(1'b1, tpc_pkg::SUB_CNT, 16'h8000);
		wr(1'b1, tpc_pkg::SUB_GEN_B, 16'h7000);
		wr(1'b0, tpc_pkg::SUB_CTRL, {13'h0000, tpc_pkg::TPSC_EXT_A});
		wr(1'b0, tpc_pkg::SUB_CNT, 16'h1234);
		wr(1'b0, tpc_pkg::SUB_IO, 16'h00CC);
		wr(1'b0, tpc_pkg::SUB_IER, 16'h0001);
		far_u.pulse(0);
		far_u.pulse(1);
		repeat (2) @(negedge REF_CLK);
		check("irq a4", irq_a[0], 1'b1);
		check("irq b4", irq_b[0], 1'b0);
		rc("cap a", 1'b0, tpc_pkg::SUB_GEN_A, 32'hFFFFFFFF, 32'h1234);
		rc("cap b", 1'b0, tpc_pkg::SUB_GEN_B, 32'hFFFFFFFF, 32'h1234);
		rc("sr4 set", 1'b0, tpc_pkg::SUB_SR, 32'hFFFFFFFF, 32'hC3);
		far_u.dma_sel <= 1'b1;
		far_u.xfer_sel <= 1'b1;
		far_u.pulse(2);
		far_u.pulse(3);
		rc("sr4 dma", 1'b0, tpc_pkg::SUB_SR, 32'hFFFFFFFF, 32'hC2);
		far_u.xfer_sel <= 1'b0;
		far_u.pulse(3);
		rc("sr4 xfer", 1'b0, tpc_pkg::SUB_SR, 32'hFFFFFFFF, 32'hC0);
		// Low lane only: the upper byte of the register must survive
		strb <= 4'h1;
		wr(1'b0, tpc_pkg::SUB_GEN_A, 16'hABCD);
		strb <= 4'hF;
		rc("lane a", 1'b0, tpc_pkg::SUB_GEN_A, 32'hFFFFFFFF, 32'h12CD);
		// Every compare output code with an action selected (six codes) on channel 5 register A
		wr(1'b1, tpc_pkg::SUB_GEN_A, 16'h0100);
		wr(1'b1, tpc_pkg::SUB_IER, 16'h0081);
		for (c = 0; c < 6; c++) begin
			code = codes[c];
			n = adc_n;
			wr(1'b1, tpc_pkg::SUB_IO, {12'h000, code});
			@(negedge REF_CLK);
			check("oe", tio_oe[2], 1'b1);
			check("init pin", tio_out[2], code[2]);
			wr(1'b1, tpc_pkg::SUB_CNT, 16'h0000);
			wait_for(0);
			exp = (code[1:0] == tpc_pkg::OUT_ZERO) ? 1'b0 : (code[1:0] == tpc_pkg::OUT_ONE) ? 1'b1 : ~code[2];
			check("match pin", tio_out[2], exp);
			wr(1'b1, tpc_pkg::SUB_SR, 16'h00FF);
			rc("sr5 set", 1'b1, tpc_pkg::SUB_SR, 32'hFFFFFFFF, 32'hC1);
			wr(1'b1, tpc_pkg::SUB_SR, 16'h0000);
			rc("sr5 clr", 1'b1, tpc_pkg::SUB_SR, 32'hFFFFFFFF, 32'hC0);
			check("irq off", irq_a[1], 1'b0);
			check("adc", adc_n - n, 32'h1);
		end
		// Upward wrap with only the overflow request enabled
		wr(1'b1, tpc_pkg::SUB_IER, 16'h0010);
		wr(1'b1, tpc_pkg::SUB_CNT, 16'hFFF0);
		wait_for(1);
		check("unf irq", irq_u[1], 1'b0);
		rc("sr5 ovf", 1'b1, tpc_pkg::SUB_SR, 32'hF0, 32'hD0);
		rc("cnt wrap", 1'b1, tpc_pkg::SUB_CNT, 32'hFF00, 32'h0);
		// Phase counting downward; the divide-by-one source must not move it
		wr(1'b1, tpc_pkg::SUB_MODE, 16'h0004);
		rc("mode5", 1'b1, tpc_pkg::SUB_MODE, 32'hFFFFFFFF, 32'hC4);
		wr(1'b1, tpc_pkg::SUB_IER, 16'h0020);
		wr(1'b1, tpc_pkg::SUB_CNT, 16'h0002);
		repeat (20) @(posedge REF_CLK);
		rc("cnt hold", 1'b1, tpc_pkg::SUB_CNT, 32'hFFFFFFFF, 32'h0002);
		far_u.quad_down(4);
		wait_for(2);
		repeat (12) @(posedge REF_CLK);
		rc("sr5 unf", 1'b1, tpc_pkg::SUB_SR, 32'hA0, 32'h20);
		rc("cnt down", 1'b1, tpc_pkg::SUB_CNT, 32'hFFFFFFFF, 32'hFFFE);
		// Synchronous clear from a neighbour while the counter stands still
		wr(1'b1, tpc_pkg::SUB_CTRL, {9'h000, tpc_pkg::CCLR_SYNC, 5'h00});
		sync <= 2'h2;
		@(posedge REF_CLK);
		sync <= 2'h0;
		rc("sync clr", 1'b1, tpc_pkg::SUB_CNT, 32'hFFFFFFFF, 32'h0000);
		final_report();
	end
endmodule : tpc_top_test
